// ### xpd_exec.sv
// execution unit for port direction load and the two xor instructions
// assumes decode holds opValid/op/operands for one cycle per instruction
`timescale 1ns/10ps
// Overview of operation
// - port direction load takes operand 5, 6 or 7 and copies the accumulator to port a, b or c direction, flags untouched.
// - literal xor puts accumulator xor an 8-bit immediate into the accumulator and touches only the zero flag.
// - file xor combines the accumulator with file register 0..127 and touches only the zero flag.
// - with destination 0 the file xor result goes to the accumulator and the file register is kept.
// - with destination 1 the file xor result goes to the file register and the accumulator is kept.
// - literal xor accepts any immediate 0..255 and always writes the accumulator, ignoring destination.
module xpd_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // decoded instruction
  input wire logic opValid,
  input wire xpd_pkg::xpd_op_t op,
  input wire logic [7:0] literal,
  input wire logic [6:0] fileAddr,
  input wire logic destBit,
  output logic busy,
  // architectural state
  output logic [7:0] acc,
  output logic zeroFlag,
  output logic [7:0] portADirection,
  output logic [7:0] portBDirection,
  output logic [7:0] portCDirection
);
  typedef enum logic {XPD_IDLE, XPD_FETCH} xpd_state_t;

  // number of direction registers built by the generate loop
  localparam int DIR_CNT = 3;

  xpd_state_t state_r;
  logic [6:0] addr_r;
  logic dest_r;
  logic [7:0] acc_r;
  logic zero_r;
  logic [7:0] fileRes;
  logic [7:0] litRes;
  logic taken;
  logic litDo;
  logic dirDo;
  logic fileDo;
  logic fileDone;
  logic fileToAcc;
  logic fileToMem;

  // whole operand compared, so values above 7 cannot alias onto a port
  function automatic logic dirHit(input logic [6:0] operand, input logic [2:0] sel);
    dirHit = (operand == {4'h0, sel});
  endfunction : dirHit

  // loop index to the operand value of each direction register
  function automatic logic [2:0] dirSel(input int idx);
    case (idx)
      0: dirSel = xpd_pkg::PORT_A_SEL;
      1: dirSel = xpd_pkg::PORT_B_SEL;
      default: dirSel = xpd_pkg::PORT_C_SEL;
    endcase
  endfunction : dirSel

  // shared by both xor flavours
  function automatic logic isZero(input logic [7:0] value);
    isZero = (value == 8'h00);
  endfunction : isZero

  // file register memory behind its own interface
  xpd_file_if fport ();

  xpd_file_mem u_mem (
    .sys_clk(sys_clk),
    .port(fport)
  );

  // an instruction is taken only while no file read is in flight
  assign busy = (state_r == XPD_FETCH);
  assign taken = opValid && !busy;
  assign litDo = taken && (op == xpd_pkg::XPD_OP_XOR_LIT);
  assign dirDo = taken && (op == xpd_pkg::XPD_OP_DIR_LOAD);
  assign fileDo = taken && (op == xpd_pkg::XPD_OP_XOR_FILE);
  assign fileDone = (state_r == XPD_FETCH);
  assign fileToAcc = fileDone && (dest_r == xpd_pkg::DEST_ACC);
  assign fileToMem = fileDone && (dest_r == xpd_pkg::DEST_FILE);

  // results of the two xor flavours
  assign litRes = acc_r ^ literal;
  assign fileRes = acc_r ^ fport.rdData;

  // read address goes straight in; the memory registers it for one cycle
  assign fport.rdAddr = fileAddr;

  // sequencer: a file xor costs one extra cycle for the registered read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= XPD_IDLE;
    end
    else
    begin
      case (state_r)
        XPD_IDLE:
        begin
          if (fileDo)
          begin
            state_r <= XPD_FETCH;
          end
        end
        XPD_FETCH:
        begin
          state_r <= XPD_IDLE;
        end
        default:
        begin
          state_r <= XPD_IDLE;
        end
      endcase
    end
  end

  // write-back address, held while the read completes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_r <= 7'h00;
    end
    else if (fileDo)
    begin
      addr_r <= fileAddr;
    end
  end

  // destination choice, held with the address
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dest_r <= xpd_pkg::DEST_ACC;
    end
    else if (fileDo)
    begin
      dest_r <= destBit;
    end
  end

  // accumulator write paths; cannot collide, litDo is blocked while busy
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= xpd_pkg::ACC_RESET;
    end
    else if (litDo)
    begin
      acc_r <= litRes;
    end
    else if (fileToAcc)
    begin
      acc_r <= fileRes;
    end
  end

  // zero flag, only the xors touch it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_r <= 1'b0;
    end
    else if (litDo)
    begin
      zero_r <= isZero(litRes);
    end
    else if (fileDone)
    begin
      zero_r <= isZero(fileRes);
    end
  end

  // file write back; memory written only on destination 1
  assign fport.wrEn = fileToMem;
  assign fport.wrAddr = addr_r;
  assign fport.wrData = fileRes;

  // one direction register per port; other operands leave all alone
  genvar gi;
  generate
    for (gi = 0; gi < DIR_CNT; gi++)
    begin : g_dir
      logic [7:0] dirQ_r;

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          dirQ_r <= xpd_pkg::DIR_RESET;
        end
        else if (dirDo && dirHit(fileAddr, dirSel(gi)))
        begin
          dirQ_r <= acc_r;
        end
      end
    end
  endgenerate

  // architectural outputs straight from their flip-flops
  assign acc = acc_r;
  assign zeroFlag = zero_r;
  assign portADirection = g_dir[0].dirQ_r;
  assign portBDirection = g_dir[1].dirQ_r;
  assign portCDirection = g_dir[2].dirQ_r;
endmodule : xpd_exec

// ### xpd_pkg.sv
// constants for the xor and port direction execution unit
// assumes an 8-bit accumulator datapath and a 128-entry file space
package xpd_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [2:0] PORT_A_SEL = 3'h5;
  localparam logic [2:0] PORT_B_SEL = 3'h6;
  localparam logic [2:0] PORT_C_SEL = 3'h7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  typedef enum logic [1:0] {
    XPD_OP_NONE,
    XPD_OP_DIR_LOAD,
    XPD_OP_XOR_LIT,
    XPD_OP_XOR_FILE
  } xpd_op_t;
endpackage : xpd_pkg

// ### xpd_file_if.sv
// port between the execution unit and its file register memory
// assumes a single clock shared by both ends
`timescale 1ns/10ps
interface xpd_file_if;
  logic [6:0] rdAddr;
  logic [7:0] rdData;
  logic wrEn;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  modport core (output rdAddr, input rdData, output wrEn, output wrAddr, output wrData);
  modport mem (input rdAddr, output rdData, input wrEn, input wrAddr, input wrData);
endinterface : xpd_file_if

// ### xpd_file_mem.sv
// file register memory, 128 x 8, registered read port
// assumes the read address is presented one cycle before data is used
`timescale 1ns/10ps
module xpd_file_mem (
  // clock
  input wire logic sys_clk,
  // access
  xpd_file_if.mem port
);
  logic [7:0] mem [xpd_pkg::FILE_DEPTH];

  // contents start at zero so a file xor never combines with an unknown
  initial
  begin
    for (int i = 0; i < xpd_pkg::FILE_DEPTH; i++)
    begin
      mem[i] = 8'h00;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (port.wrEn)
    begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    port.rdData <= mem[port.rdAddr];
  end
endmodule : xpd_file_mem

// ### xpd_exec_sva.sv
// checker on the execution unit ports
// assumes bind onto xpd_exec, one clock
`timescale 1ns/10ps
module xpd_exec_sva (
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire xpd_pkg::xpd_op_t op,
  input wire logic [7:0] literal,
  input wire logic [6:0] fileAddr,
  input wire logic destBit,
  input wire logic busy,
  input wire logic [7:0] acc,
  input wire logic zeroFlag,
  input wire logic [7:0] portADirection,
  input wire logic [7:0] portBDirection,
  input wire logic [7:0] portCDirection
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire tk = opValid && !busy;
  wire dl = tk && op == xpd_pkg::XPD_OP_DIR_LOAD;
  wire xl = tk && op == xpd_pkg::XPD_OP_XOR_LIT;
  wire xf = tk && op == xpd_pkg::XPD_OP_XOR_FILE;
  dir_load_a: assert property (dl && fileAddr == 7'h05 |=> portADirection == $past(acc))
    else $error("dir load");
  dir_bad_a: assert property (dl && (fileAddr < 7'h05 || fileAddr > 7'h07)
    |=> $stable({portADirection, portBDirection, portCDirection}))
    else $error("dir bad");
  dir_flag_a: assert property (dl |=> $stable({acc, zeroFlag})) else $error("dir flag");
  lit_xor_a: assert property (xl |=> acc == ($past(acc) ^ $past(literal))) else $error("lit xor");
  lit_zero_a: assert property (xl |=> zeroFlag == (acc == 8'h00)) else $error("lit zero");
  file_busy_a: assert property (xf |=> busy ##1 !busy) else $error("file busy");
  file_keep_a: assert property (xf && destBit |-> ##2 acc == $past(acc, 2)) else $error("file keep");
  file_zero_a: assert property (xf && !destBit |-> ##2 zeroFlag == (acc == 8'h00)) else $error("file zero");
  cover property (dl);
  cover property (xl ##1 zeroFlag);
  cover property (xf && destBit);
endmodule : xpd_exec_sva
bind xpd_exec xpd_exec_sva chk (.*);

// ### testbench.sv
// bench for the execution unit
// assumes the unit alone, checker bound
`timescale 1ns/10ps
module testbench;
  localparam xpd_pkg::xpd_op_t L = xpd_pkg::XPD_OP_XOR_LIT;
  localparam xpd_pkg::xpd_op_t D = xpd_pkg::XPD_OP_DIR_LOAD;
  localparam xpd_pkg::xpd_op_t F = xpd_pkg::XPD_OP_XOR_FILE;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic opValid = 1'b0;
  xpd_pkg::xpd_op_t op = xpd_pkg::XPD_OP_NONE;
  logic [7:0] literal = 8'h00;
  logic [6:0] fileAddr = 7'h00;
  logic destBit = 1'b0;
  logic busy;
  logic zeroFlag;
  logic [7:0] acc, portADirection, portBDirection, portCDirection;
  int error_cnt = 0;
  int check_count = 0;
  xpd_exec uut (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic ck(string n, logic [7:0] s, logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : ck
  task automatic go(xpd_pkg::xpd_op_t o, logic [7:0] k, logic [6:0] a, logic d);
    @(posedge sys_clk);
    opValid <= 1'b1;
    op <= o;
    literal <= k;
    fileAddr <= a;
    destBit <= d;
    @(posedge sys_clk);
    opValid <= 1'b0;
    repeat (o == F ? 2 : 0) @(posedge sys_clk);
    #1;
  endtask : go
  task automatic t_lit;
    go(L, 8'hA5, 7'h00, 1'b1);
    ck("acc", acc, 8'hA5);
    go(L, 8'hA5, 7'h00, 1'b0);
    ck("acc", acc, 8'h00);
    ck("zero", zeroFlag, 8'h01);
  endtask : t_lit
  task automatic t_dir;
    go(L, 8'hC3, 7'h00, 1'b0);
    go(D, 8'h00, 7'h05, 1'b0);
    ck("dirA", portADirection, 8'hC3);
    go(D, 8'h00, 7'h7E, 1'b0);
    ck("dirB", portBDirection, 8'hFF);
    go(D, 8'h00, 7'h06, 1'b0);
    ck("dirB", portBDirection, 8'hC3);
    go(L, 8'hC3, 7'h00, 1'b0);
    go(D, 8'h00, 7'h04, 1'b0);
    ck("dirA", portADirection, 8'hC3);
    go(D, 8'h00, 7'h07, 1'b0);
    ck("dirC", portCDirection, 8'h00);
    ck("zero", zeroFlag, 8'h01);
  endtask : t_dir
  task automatic t_file;
    go(L, 8'h5A, 7'h00, 1'b0);
    go(F, 8'hFF, 7'h7F, 1'b1);
    ck("acc", acc, 8'h5A);
    ck("zero", zeroFlag, 8'h00);
    go(F, 8'hFF, 7'h7F, 1'b0);
    ck("acc", acc, 8'h00);
    ck("zero", zeroFlag, 8'h01);
    go(L, 8'h3C, 7'h00, 1'b0);
    go(F, 8'h00, 7'h7F, 1'b0);
    ck("acc", acc, 8'h66);
  endtask : t_file
  task automatic t_busy;
    @(posedge sys_clk);
    opValid <= 1'b1;
    op <= F;
    fileAddr <= 7'h10;
    destBit <= 1'b0;
    @(posedge sys_clk);
    op <= L;
    literal <= 8'hFF;
    #1;
    ck("busy", busy, 8'h01);
    @(posedge sys_clk);
    opValid <= 1'b0;
    #1;
    ck("busy", busy, 8'h00);
    ck("acc", acc, 8'h66);
  endtask : t_busy
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial
  begin
    // hang guard
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    ck("dirA", portADirection, 8'hFF);
    ck("acc", acc, 8'h00);
    t_lit();
    t_dir();
    t_file();
    t_busy();
    print_verdict();
  end
endmodule : testbench
